// File: rtl/dual_uart_map.svh
`ifndef DUAL_UART_MAP_SVH
`define DUAL_UART_MAP_SVH

// Register offsets per port; port 1 adds PORT_STRIDE
`define RX_DATA_OFS      6'h00
`define TX_DATA_OFS      6'h01
`define LINE_CTRL_OFS    6'h02
`define LINE_STAT_OFS    6'h03
`define INT_STAT_OFS     6'h04
`define INT_MASK_OFS     6'h05
`define BAUD_DIV_OFS     6'h06
`define PORT_STRIDE      6'h10

// Line control fields
`define LC_LEN_LSB       0
`define LC_STOP_BIT      2
`define LC_PAR_EN_BIT    3
`define LC_EVEN_BIT      4
`define LC_FORCE_BIT     5
`define LC_BREAK_BIT     6
`define LC_FIFO_EN_BIT   7
`define LC_RESET         8'h00

// Interrupt event bits
`define EV_RX_AVAIL      0
`define EV_TX_EMPTY      1
`define EV_LINE_ERR      2

`define FIFO_DEPTH       32
`define OVERSAMPLE       16
`define BAUD_DIV_RESET   16'h006c

`endif

// File: rtl/dual_uart_pkg.sv
package dual_uart_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_START, S_DATA, S_PAR, S_STOP
  } ser_state_t;
  typedef logic [7:0] byte_t;
endpackage

// File: rtl/dual_uart_data_line_control.sv
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/10ps
`include "dual_uart_map.svh"

// What this block does
// - Each receiver converts serial bits into bytes kept in a 32-byte FIFO.
// - Data registers answer both the microcontroller bus and the DMA port.
// - Transmit holding byte moves into a shift register, shifted onto output.
// - Transmit data is write-only, receive data read-only, both reset to zero.
// - Two-bit word length field selects 5, 6, 7 or 8 data bits.
// - Stop select clear: one stop bit; else 1.5 for 5-bit words, 2 otherwise.
// - Parity enable adds a parity bit to each character.
// - Even select chooses even parity when set, odd when clear.
// - Forced parity with even select clear sends constant one.
// - Break control holds serial output low.
// - FIFO enable clear empties the receive FIFO and asserts flow control.
// - FIFO enable set lets the receive FIFO accept characters.
// - Status can interrupt; a mask gates three sources per port.
// - Data moves by DMA normally, or directly by the microcontroller.
// - Line control resets to zero: 5 bits, 1 stop, no parity.
module dual_uart_data_line_control #(
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  input  wire logic [5:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output      logic [7:0]            reg_rdata,
  input  wire logic [1:0]            dma_rx_rd,
  output      dual_uart_pkg::byte_t  dma_rx_data [2],
  output      logic [1:0]            dma_rx_avail,
  input  wire logic [1:0]            dma_tx_wr,
  input  wire logic [15:0]           dma_tx_data,
  output      logic [1:0]            dma_tx_ready,
  input  wire logic [1:0]            serial_in_pin,
  output      logic [1:0]            serial_out_pin,
  output      logic [1:0]            rx_flow_stop,
  output      logic [1:0]            irq
);
  import dual_uart_pkg::*;

  localparam int AW = $clog2(DEPTH);

  function automatic logic [3:0] data_bits(input logic [1:0] wl);
    data_bits = 4'(wl) + 4'h5;
  endfunction

  function automatic logic par_bit(input logic [7:0] lc, input byte_t d);
    logic       x;
    logic [7:0] m;
    // Parity covers only the data bits sent on the line
    m = d & (8'hff >> (2'd3 - lc[1:0]));
    x = ^m;
    if (lc[`LC_FORCE_BIT]) begin
      par_bit = ~lc[`LC_EVEN_BIT];
    end else begin
      par_bit = lc[`LC_EVEN_BIT] ? x : ~x;
    end
  endfunction

  logic [7:0] rdata_next;

  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [7:0]  line_ctrl_reg;
    logic [2:0]  int_stat_reg, int_mask_reg;
    logic [15:0] baud_div_reg;
    logic [15:0] tick_cnt_reg;
    logic        tick;
    logic [5:0]  ofs;
    logic        sel, wr_lc, wr_tx, wr_st, wr_mk, rd_rx;
    logic        wr_div_lo, wr_div_hi;
    logic [2:0]  sync_reg;
    logic        rx_in;
    byte_t       mem [DEPTH];
    logic [AW:0] wp_reg, rp_reg;
    logic [AW:0] count;
    logic        fifo_full, fifo_empty, pop;
    byte_t       tx_hold_reg;
    logic        tx_hold_full_reg;
    ser_state_t  tx_state_reg;
    byte_t       tx_shift_reg;
    logic [3:0]  tx_bit_reg;
    logic [5:0]  tx_sub_reg;
    logic        tx_par_reg;
    logic        tx_line;
    logic        serial_out_pin_reg;
    ser_state_t  rx_state_reg;
    byte_t       rx_shift_reg;
    logic [3:0]  rx_bit_reg;
    logic [3:0]  rx_sub_reg;
    logic        rx_par_reg;
    logic        push, rx_err, tx_load;
    logic [2:0]  events;
    logic [7:0]  lc;

    assign lc = line_ctrl_reg;
    assign ofs = reg_addr - (p == 0 ? 6'h00 : `PORT_STRIDE);
    assign sel = (p == 0) ? (reg_addr < `PORT_STRIDE)
                          : (reg_addr >= `PORT_STRIDE);
    assign wr_lc = reg_wr && sel && ofs == `LINE_CTRL_OFS;
    assign wr_tx = reg_wr && sel && ofs == `TX_DATA_OFS;
    assign wr_st = reg_wr && sel && ofs == `INT_STAT_OFS;
    assign wr_mk = reg_wr && sel && ofs == `INT_MASK_OFS;
    assign wr_div_lo = reg_wr && sel && ofs == `BAUD_DIV_OFS;
    assign wr_div_hi = reg_wr && sel && ofs == (`BAUD_DIV_OFS + 6'h01);
    assign rd_rx = reg_rd && sel && ofs == `RX_DATA_OFS;

    // Line control, mask and divisor
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        line_ctrl_reg <= `LC_RESET;
        int_mask_reg  <= 3'h0;
        baud_div_reg  <= `BAUD_DIV_RESET;
      end else begin
        if (wr_lc) line_ctrl_reg <= reg_wdata;
        if (wr_mk) int_mask_reg <= reg_wdata[2:0];
        if (wr_div_lo) baud_div_reg[7:0] <= reg_wdata;
        if (wr_div_hi) baud_div_reg[15:8] <= reg_wdata;
      end
    end

    // Oversample tick at 16x bit rate
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        tick_cnt_reg <= 16'h0000;
      end else if (tick) begin
        tick_cnt_reg <= 16'h0000;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      end
    end
    assign tick = tick_cnt_reg >= baud_div_reg;

    // Pin synchroniser
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        sync_reg <= 3'b111;
        rx_in    <= 1'b1;
      end else begin
        sync_reg <= {sync_reg[1:0], serial_in_pin[p]};
        if (sync_reg[1] == sync_reg[2]) rx_in <= sync_reg[2];
      end
    end

    // Receive FIFO
    assign count      = wp_reg - rp_reg;
    assign fifo_full  = count == (AW+1)'(DEPTH);
    assign fifo_empty = count == '0;
    assign pop = (rd_rx || dma_rx_rd[p]) && !fifo_empty;
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        wp_reg <= '0;
        rp_reg <= '0;
      end else if (!lc[`LC_FIFO_EN_BIT]) begin
        wp_reg <= '0;
        rp_reg <= '0;
      end else begin
        if (push && !fifo_full) wp_reg <= wp_reg + 1'b1;
        if (pop) rp_reg <= rp_reg + 1'b1;
      end
    end
    always_ff @(posedge core_clk) begin
      if (push && !fifo_full && lc[`LC_FIFO_EN_BIT]) begin
        mem[wp_reg[AW-1:0]] <= rx_shift_reg;
      end
    end
    assign dma_rx_data[p] = fifo_empty ? 8'h00 : mem[rp_reg[AW-1:0]];
    assign dma_rx_avail[p] = !fifo_empty;
    assign rx_flow_stop[p] = !lc[`LC_FIFO_EN_BIT];

    // Receiver, samples mid-bit
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        rx_state_reg <= S_IDLE;
        rx_shift_reg <= 8'h00;
        rx_bit_reg   <= 4'h0;
        rx_sub_reg   <= 4'h0;
        rx_par_reg   <= 1'b0;
        push         <= 1'b0;
        rx_err       <= 1'b0;
      end else begin
        push   <= 1'b0;
        rx_err <= 1'b0;
        if (tick) begin
          rx_sub_reg <= rx_sub_reg + 4'h1;
          case (rx_state_reg)
            S_IDLE: begin
              rx_sub_reg <= 4'h0;
              if (!rx_in) rx_state_reg <= S_START;
            end
            S_START: begin
              if (rx_sub_reg == 4'h7) begin
                rx_sub_reg   <= 4'h0;
                rx_bit_reg   <= 4'h0;
                rx_shift_reg <= 8'h00;
                rx_state_reg <= rx_in ? S_IDLE : S_DATA;
              end
            end
            S_DATA: begin
              if (rx_sub_reg == 4'hf) begin
                rx_shift_reg[rx_bit_reg[2:0]] <= rx_in;
                rx_bit_reg <= rx_bit_reg + 4'h1;
                if (rx_bit_reg == data_bits(lc[1:0]) - 4'h1) begin
                  rx_state_reg <= lc[`LC_PAR_EN_BIT] ? S_PAR : S_STOP;
                end
              end
            end
            S_PAR: begin
              if (rx_sub_reg == 4'hf) begin
                rx_par_reg   <= rx_in;
                rx_state_reg <= S_STOP;
              end
            end
            S_STOP: begin
              if (rx_sub_reg == 4'hf) begin
                rx_state_reg <= S_IDLE;
                push   <= 1'b1;
                rx_err <= !rx_in || (lc[`LC_PAR_EN_BIT] &&
                          rx_par_reg != par_bit(lc, rx_shift_reg));
              end
            end
            default: rx_state_reg <= S_IDLE;
          endcase
        end
      end
    end

    // Transmit holding register
    assign tx_load = tx_state_reg == S_IDLE && tx_hold_full_reg && tick;
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        tx_hold_reg      <= 8'h00;
        tx_hold_full_reg <= 1'b0;
      end else if (wr_tx || dma_tx_wr[p]) begin
        tx_hold_reg      <= wr_tx ? reg_wdata : dma_tx_data[8*p +: 8];
        tx_hold_full_reg <= 1'b1;
      end else if (tx_load) begin
        tx_hold_full_reg <= 1'b0;
      end
    end
    assign dma_tx_ready[p] = !tx_hold_full_reg;

    // Transmit shifter
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        tx_state_reg <= S_IDLE;
        tx_shift_reg <= 8'h00;
        tx_bit_reg   <= 4'h0;
        tx_sub_reg   <= 6'h00;
        tx_par_reg   <= 1'b0;
        tx_line      <= 1'b1;
      end else if (tick) begin
        tx_sub_reg <= tx_sub_reg + 6'h01;
        case (tx_state_reg)
          S_IDLE: begin
            tx_line <= 1'b1;
            if (tx_load) begin
              tx_shift_reg <= tx_hold_reg;
              tx_par_reg   <= par_bit(lc, tx_hold_reg);
              tx_line      <= 1'b0;
              tx_sub_reg   <= 6'h00;
              tx_state_reg <= S_START;
            end
          end
          S_START: begin
            if (tx_sub_reg == 6'h0f) begin
              tx_sub_reg   <= 6'h00;
              tx_bit_reg   <= 4'h0;
              tx_line      <= tx_shift_reg[0];
              tx_state_reg <= S_DATA;
            end
          end
          S_DATA: begin
            if (tx_sub_reg == 6'h0f) begin
              tx_sub_reg <= 6'h00;
              tx_bit_reg <= tx_bit_reg + 4'h1;
              if (tx_bit_reg == data_bits(lc[1:0]) - 4'h1) begin
                if (lc[`LC_PAR_EN_BIT]) begin
                  tx_line      <= tx_par_reg;
                  tx_state_reg <= S_PAR;
                end else begin
                  tx_line      <= 1'b1;
                  tx_state_reg <= S_STOP;
                end
              end else begin
                tx_line <= tx_shift_reg[3'(tx_bit_reg + 4'h1)];
              end
            end
          end
          S_PAR: begin
            if (tx_sub_reg == 6'h0f) begin
              tx_sub_reg   <= 6'h00;
              tx_line      <= 1'b1;
              tx_state_reg <= S_STOP;
            end
          end
          S_STOP: begin
            // Stop length in ticks: 16, 24 or 32
            if (tx_sub_reg == (!lc[`LC_STOP_BIT] ? 6'h0f :
                (lc[1:0] == 2'b00 ? 6'h17 : 6'h1f))) begin
              tx_sub_reg   <= 6'h00;
              tx_state_reg <= S_IDLE;
            end
          end
          default: tx_state_reg <= S_IDLE;
        endcase
      end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        serial_out_pin_reg <= 1'b1;
      end else begin
        serial_out_pin_reg <= lc[`LC_BREAK_BIT] ? 1'b0 : tx_line;
      end
    end
    assign serial_out_pin[p] = serial_out_pin_reg;

    // Sticky events, set wins over write-one clear
    assign events = {rx_err || (push && fifo_full), tx_load, push};
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        int_stat_reg <= 3'h0;
      end else begin
        int_stat_reg <= (int_stat_reg & ~(wr_st ? reg_wdata[2:0] : 3'h0))
                        | events;
      end
    end
    assign irq[p] = |(int_stat_reg & int_mask_reg);
  end

  function automatic logic [7:0] port_read(
    input logic [5:0] o, input logic [7:0] lc, input logic [7:0] rx,
    input logic [7:0] ls, input logic [2:0] st, input logic [2:0] mk,
    input logic [15:0] dv);
    case (o)
      `RX_DATA_OFS:            port_read = rx;
      `LINE_CTRL_OFS:          port_read = lc;
      `LINE_STAT_OFS:          port_read = ls;
      `INT_STAT_OFS:           port_read = {5'h00, st};
      `INT_MASK_OFS:           port_read = {5'h00, mk};
      `BAUD_DIV_OFS:           port_read = dv[7:0];
      `BAUD_DIV_OFS + 6'h01:   port_read = dv[15:8];
      default:                 port_read = 8'h00;
    endcase
  endfunction

  always_comb begin
    if (reg_addr < `PORT_STRIDE) begin
      rdata_next = port_read(g_port[0].ofs, g_port[0].line_ctrl_reg,
        dma_rx_data[0], {6'h00, dma_tx_ready[0], dma_rx_avail[0]},
        g_port[0].int_stat_reg, g_port[0].int_mask_reg,
        g_port[0].baud_div_reg);
    end else begin
      rdata_next = port_read(g_port[1].ofs, g_port[1].line_ctrl_reg,
        dma_rx_data[1], {6'h00, dma_tx_ready[1], dma_rx_avail[1]},
        g_port[1].int_stat_reg, g_port[1].int_mask_reg,
        g_port[1].baud_div_reg);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
    end
  end
endmodule

// File: testbench/dual_uart_dlc_asserts.sv
`timescale 1ns/10ps
module dual_uart_dlc_asserts #(
  parameter int DEPTH = 32
) (
  input logic                 core_clk,
  input logic                 arst_n,
  input logic [5:0]           reg_addr,
  input logic [7:0]           reg_wdata,
  input logic                 reg_wr,
  input logic                 reg_rd,
  input logic [7:0]           reg_rdata,
  input logic [1:0]           dma_rx_rd,
  input dual_uart_pkg::byte_t dma_rx_data [2],
  input logic [1:0]           dma_rx_avail,
  input logic [1:0]           dma_tx_wr,
  input logic [15:0]          dma_tx_data,
  input logic [1:0]           dma_tx_ready,
  input logic [1:0]           serial_in_pin,
  input logic [1:0]           serial_out_pin,
  input logic [1:0]           rx_flow_stop,
  input logic [1:0]           irq
);
  import dual_uart_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero");
  a_lc_flow_stop: assert property (reg_wr && reg_addr == 6'h02
    |=> rx_flow_stop[0] == !$past(reg_wdata[7])) else $error("flow stop");
  a_fifo_off_empty: assert property (reg_wr && reg_addr == 6'h02
    && !reg_wdata[7] |-> ##2 !dma_rx_avail[0]) else $error("fifo kept");
  a_empty_head_zero: assert property (!dma_rx_avail[1]
    |-> dma_rx_data[1] == 8'h00) else $error("head not zero");
  a_tx_ready_drop: assert property (dma_tx_wr[1] && dma_tx_ready[1]
    |=> !dma_tx_ready[1]) else $error("holding not taken");
  a_start_follows: assert property ($fell(dma_tx_ready[1])
    |-> ##[1:800] !serial_out_pin[1]) else $error("no start bit");
  a_break_low: assert property (reg_wr && reg_addr == 6'h12
    && reg_wdata[6] |-> ##3 !serial_out_pin[1] [*8]) else $error("no break");
  a_mask_gates_irq: assert property (reg_wr && reg_addr == 6'h05
    && reg_wdata[2:0] == 3'b000 |-> ##2 !irq[0]) else $error("irq unmasked");
endmodule

// File: testbench/serial_peer_model.sv
`timescale 1ns/10ps
module serial_peer_model #(
  parameter int BIT = 32
) (
  input logic        core_clk,
  input logic [1:0]  serial_out_pin,
  output logic [1:0] serial_in_pin
);
  int miss = 0;
  int cyc = 0;
  initial serial_in_pin = 2'b11;
  always @(posedge core_clk) cyc <= cyc + 1;
  function automatic int nbits(logic [7:0] lc);
    return 5 + lc[1:0];
  endfunction
  function automatic logic pbit(logic [7:0] lc, logic [7:0] d);
    logic [7:0] m;
    m = d & (8'hff >> (3 - lc[1:0]));
    return lc[5] ? !lc[4] : (lc[4] ? ^m : ~^m);
  endfunction
  task automatic send(int p, logic [7:0] d, logic [7:0] lc);
    @(posedge core_clk) serial_in_pin[p] <= 1'b0;
    repeat (BIT) @(posedge core_clk);
    for (int i = 0; i < nbits(lc); i++) begin
      serial_in_pin[p] <= d[i];
      repeat (BIT) @(posedge core_clk);
    end
    if (lc[3]) begin
      serial_in_pin[p] <= pbit(lc, d);
      repeat (BIT) @(posedge core_clk);
    end
    serial_in_pin[p] <= 1'b1;
    repeat (lc[2] ? 2 * BIT : BIT) @(posedge core_clk);
  endtask
  task automatic grab(int p, logic [7:0] lc, output logic [7:0] d,
                      output logic pa, output int t);
    int k;
    d = 8'h00;
    pa = 1'b0;
    k = 0;
    while (serial_out_pin[p] !== 1'b0 && k < 2000) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 2000) miss++;
    t = cyc;
    repeat (BIT / 2) @(posedge core_clk);
    for (int i = 0; i < nbits(lc); i++) begin
      repeat (BIT) @(posedge core_clk);
      d[i] = serial_out_pin[p];
    end
    if (lc[3]) begin
      repeat (BIT) @(posedge core_clk);
      pa = serial_out_pin[p];
    end
    repeat (BIT) @(posedge core_clk);
    if (serial_out_pin[p] !== 1'b1) miss++;
  endtask
endmodule

// File: testbench/dual_uart_data_line_control_tb.sv
`timescale 1ns/10ps
module dual_uart_data_line_control_tb;
  import dual_uart_pkg::*;
  logic        core_clk, arst_n, reg_wr, reg_rd;
  logic [5:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [1:0]  dma_rx_rd, dma_rx_avail, dma_tx_wr, dma_tx_ready, irq;
  logic [1:0]  serial_in_pin, serial_out_pin, rx_flow_stop;
  logic [15:0] dma_tx_data;
  byte_t       dma_rx_data [2];
  int          fail_count = 0;
  int          n_compared = 0;
  int          seed = 84;
  dual_uart_data_line_control #(.DEPTH(32)) dut (.core_clk(core_clk),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dma_rx_rd(dma_rx_rd), .dma_rx_data(dma_rx_data),
    .dma_rx_avail(dma_rx_avail), .dma_tx_wr(dma_tx_wr),
    .dma_tx_data(dma_tx_data), .dma_tx_ready(dma_tx_ready),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .rx_flow_stop(rx_flow_stop), .irq(irq));
  serial_peer_model #(.BIT(32)) model (.core_clk(core_clk),
    .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [5:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wt(int p, bit tx);
    int k = 0;
    #1;
    while ((tx ? dma_tx_ready[p] : dma_rx_avail[p]) !== 1'b1) begin
      @(posedge core_clk);
      k++;
      if (k > 3000) begin
        fail_count++;
        stop_test();
      end
    end
  endtask
  task automatic put_tx(int p, logic [7:0] d);
    wt(p, 1);
    if (p == 0) wr(6'h01, d);
    else begin
      @(posedge core_clk);
      dma_tx_wr[1] <= 1'b1;
      dma_tx_data[15:8] <= d;
      @(posedge core_clk);
      dma_tx_wr[1] <= 1'b0;
    end
  endtask
  task automatic get_rx(int p, output logic [7:0] d);
    wt(p, 0);
    if (p == 0) rd(6'h00, d);
    else begin
      @(posedge core_clk);
      d = dma_rx_data[1];
      dma_rx_rd[1] <= 1'b1;
      @(posedge core_clk);
      dma_rx_rd[1] <= 1'b0;
    end
  endtask
  task automatic run_port(int p, logic [7:0] lc);
    logic [7:0] a, b, c, d1, d2, g, m;
    logic       pa, pb;
    int         t1, t2, n;
    a = $random(seed);
    b = $random(seed);
    c = $random(seed);
    n = model.nbits(lc);
    m = 8'hff >> (8 - n);
    fork
      model.send(p, c, lc);
      begin
        put_tx(p, a);
        put_tx(p, b);
      end
      begin
        model.grab(p, lc, d1, pa, t1);
        model.grab(p, lc, d2, pb, t2);
      end
    join
    chk("tx data", {d1, d2}, {a & m, b & m});
    chk("parity", {pa, pb}, lc[3] ? {model.pbit(lc, a),
      model.pbit(lc, b)} : 2'b00);
    chk("frame", (t2 - t1 + 4) / 16, 2 * (1 + n + lc[3])
      + (lc[2] ? (n == 5 ? 3 : 4) : 2));
    get_rx(p, g);
    chk("rx data", g, c & m);
  endtask
  initial begin
    logic [7:0] v, q [33];
    logic [2:0] pm [5];
    pm = '{3'b000, 3'b001, 3'b011, 3'b101, 3'b111};
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    dma_rx_rd = 2'b00;
    dma_tx_wr = 2'b00;
    dma_tx_data = 16'h0000;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    chk("reset pins", {serial_out_pin, rx_flow_stop,
      dma_tx_ready, dma_rx_avail, irq}, 16'h03f0);
    wr(6'h08, 8'hff);
    for (int i = 0; i < 9; i++) begin
      rd((i < 8) ? 6'(i % 3 + 16 * (i / 3 % 2)) : 6'h08, v);
      chk("reset reg", v, 8'h00);
    end
    $display("reset test done");
    wr(6'h06, 8'h01);
    wr(6'h07, 8'h00);
    wr(6'h16, 8'h01);
    wr(6'h17, 8'h00);
    for (int i = 0; i < 40; i++) begin
      v = {2'b10, pm[i % 5], i[2], i[1:0]};
      wr(6'h02, v);
      wr(6'h12, v ^ 8'h04);
      rd(6'h02, q[0]);
      chk("line ctrl", q[0], v);
      fork
        run_port(0, v);
        run_port(1, v ^ 8'h04);
      join
    end
    $display("format test done");
    wr(6'h02, 8'h83);
    wr(6'h04, 8'h07);
    for (int i = 0; i < 33; i++) begin
      q[i] = $random(seed);
      model.send(0, q[i], 8'h83);
    end
    rd(6'h04, v);
    chk("overrun", v[2], 1'b1);
    wr(6'h05, 8'h04);
    repeat (2) @(posedge core_clk);
    #1 chk("irq on", irq[0], 1'b1);
    for (int i = 0; i < 32; i++) begin
      rd(6'h00, v);
      chk("fifo", v, q[i]);
    end
    rd(6'h00, v);
    chk("empty read", {dma_rx_avail[0], v}, 9'h000);
    rd(6'h03, v);
    chk("line status", v, 8'h02);
    wr(6'h04, 8'h07);
    model.send(0, 8'h5a, 8'h83);
    chk("irq masked", irq[0], 1'b0);
    wr(6'h05, 8'h01);
    repeat (2) @(posedge core_clk);
    #1 chk("irq rx", irq[0], 1'b1);
    wr(6'h05, 8'h00);
    wr(6'h02, 8'h03);
    model.send(0, 8'h33, 8'h03);
    chk("fifo off", {dma_rx_avail[0], rx_flow_stop[0]}, 2'b01);
    wr(6'h02, 8'h83);
    model.send(0, 8'h66, 8'h83);
    get_rx(0, v);
    chk("fifo on", {v, dma_rx_avail[0]}, 9'h0cc);
    $display("fifo test done");
    wr(6'h12, 8'h43);
    repeat (20) @(posedge core_clk);
    chk("break", serial_out_pin[1], 1'b0);
    wr(6'h12, 8'h03);
    repeat (40) @(posedge core_clk);
    chk("no break", serial_out_pin[1], 1'b1);
    chk("peer", model.miss, 0);
    $display("break test done");
    stop_test();
  end
endmodule
bind dual_uart_data_line_control dual_uart_dlc_asserts #(.DEPTH(DEPTH)) u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .dma_rx_rd(dma_rx_rd), .dma_rx_data(dma_rx_data),
  .dma_rx_avail(dma_rx_avail), .dma_tx_wr(dma_tx_wr),
  .dma_tx_data(dma_tx_data), .dma_tx_ready(dma_tx_ready),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .rx_flow_stop(rx_flow_stop), .irq(irq));
